// [hw/watchdog_timeout_unit.sv]
`timescale 1ns/1ps
// Purpose: Watchdog timer with AHB-Lite register access.
// Assumes: Single clock; system state pins are asynchronous.
// Notes:   Progress advances once per 1/256 of the period.
module watchdog_timeout_unit
  import wdt_pkg::*;
#(
  parameter int STEP_CYC = STEP_CYCLES
) (
  input  wire logic        core_clk_in,
  input  wire logic        nrst_in,
  input  wire logic        hsel_in,
  input  wire logic [11:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic      [31:0] hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  input  wire logic        sleep_in,
  input  wire logic        deep_sleep_in,
  input  wire logic        debug_stall_in,
  input  wire logic        flash_busy_in,
  input  wire logic        wdt_reset_seen_in,
  output logic             chip_reset_out,
  output logic             exception_out,
  output logic             prog_mode_out
);

  // Pin levels crossing into the core clock
  sys_state_t sys_sync;
  wdt_sync2 #(.W($bits(sys_state_t))) wdt_sync2_i (
    .core_clk_in (core_clk_in),
    .nrst_in     (nrst_in),
    .async_in    ({sleep_in, deep_sleep_in, debug_stall_in, flash_busy_in}),
    .sync_out    (sys_sync)
  );

  // Bus address phase capture
  logic        wr_pend_reg;
  logic        wr_pend_next;
  logic        rd_pend_next;
  logic [11:0] addr_reg;
  logic [11:0] addr_next;
  logic [31:0] hrdata_next;
  logic        hreadyout_next;
  logic        hresp_next;

  // Watchdog state
  run_state_t  run_reg;
  run_state_t  run_next;
  logic [3:0]  index_reg;
  logic [3:0]  index_next;
  logic        exc_sel_reg;
  logic        exc_sel_next;
  logic        flag_reg;
  logic        flag_next;
  logic        flag_cap_reg;
  logic        flag_cap_next;
  logic [31:0] div_reg;
  logic [31:0] div_next;
  logic [12:0] sub_reg;
  logic [12:0] sub_next;
  logic [7:0]  prog_reg;
  logic [7:0]  prog_next;
  expiry_t     exp_reg;
  expiry_t     exp_next;

  // Strobes decoded from the bus and the counters
  logic        taken;
  logic        wr_now;
  logic        ctrl_wr;
  logic [3:0]  cmd_bits;
  logic        cmd_start;
  logic        cmd_stop;
  logic        cmd_kick;
  logic        cmd_clrf;
  logic [3:0]  wr_index;
  logic        halted;
  logic        running;
  logic        counting;
  logic        step;
  logic        sub_wrap;
  logic        prog_top;
  logic        expire;
  logic        fire;
  logic [12:0] mult;

  // Register decode for the write path; the read path decodes haddr_in with a case
  function automatic logic addr_is(input logic [11:0] a, input logic [11:0] reg_addr);
    return a == reg_addr;
  endfunction

  // Index values above the top period are refused
  function automatic logic index_ok(input logic [3:0] idx);
    return idx <= INDEX_MAX;
  endfunction

  // Read words, packed the same way the writes are unpacked
  function automatic logic [31:0] ctrl_word(input logic [3:0] idx, input logic exc);
    logic [31:0] w;
    w                             = '0;
    w[CTRL_IDX_LSB +: $bits(idx)] = idx;
    w[CTRL_EXC_BIT]               = exc;
    return w;
  endfunction

  function automatic logic [31:0] status_word(input logic run, input logic flag);
    logic [31:0] w;
    w              = '0;
    w[ST_RUN_BIT]  = run;
    w[ST_FLAG_BIT] = flag;
    return w;
  endfunction

  // Group: bus address phase
  assign taken  = hsel_in && hready_in && htrans_in[1];
  assign wr_now = wr_pend_reg;

  always_comb begin
    wr_pend_next = taken && hwrite_in;
    rd_pend_next = taken && !hwrite_in;
    addr_next    = taken ? haddr_in : addr_reg;
    if (!nrst_in) begin
      wr_pend_next = 1'b0;
      rd_pend_next = 1'b0;
      addr_next    = '0;
    end
  end

  always_ff @(posedge core_clk_in) begin
    wr_pend_reg <= wr_pend_next;
    addr_reg    <= addr_next;
  end

  // Group: command strobes, one per bit of the command word
  // Write data follows a cycle later, so decode uses the held address
  assign ctrl_wr = wr_now && addr_is(addr_reg, ADDR_CTRL);
  generate
    for (genvar k = 0; k < $bits(cmd_bits); k++) begin : g_cmd
      assign cmd_bits[k] = wr_now && addr_is(addr_reg, ADDR_CMD) && hwdata_in[k];
    end
  endgenerate
  assign cmd_start = cmd_bits[CMD_START_BIT];
  assign cmd_stop  = cmd_bits[CMD_STOP_BIT];
  assign cmd_kick  = cmd_bits[CMD_KICK_BIT];
  assign cmd_clrf  = cmd_bits[CMD_CLRF_BIT];
  assign wr_index  = hwdata_in[CTRL_IDX_LSB +: $bits(wr_index)];

  // Group: read data, launched at the address phase edge
  always_comb begin
    hrdata_next = '0;
    if (rd_pend_next) begin
      case (haddr_in)
        ADDR_CTRL: begin
          hrdata_next = ctrl_word(index_reg, exc_sel_reg);
        end
        ADDR_STATUS: begin
          hrdata_next = status_word(running, flag_reg);
        end
        // Straight off the counter; one register, so a read on a step cannot tear
        ADDR_PROGRESS: begin
          hrdata_next[$bits(prog_reg)-1:0] = prog_reg;
        end
        default: begin
          hrdata_next = '0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_in) begin
    hrdata_out <= hrdata_next;
  end

  // Group: bus response; zero-wait slave, always OKAY
  always_comb begin
    hreadyout_next = 1'b1;
    hresp_next     = 1'b0;
  end

  always_ff @(posedge core_clk_in) begin
    hreadyout_out <= hreadyout_next;
    hresp_out     <= hresp_next;
  end

  // Group: run state
  always_comb begin
    run_next = run_reg;
    // Start never touches the count, only the run state
    if (cmd_start) begin
      run_next = RUN_ST;
    end
    // Stop wins over a start in the same write
    if (cmd_stop) begin
      run_next = STOP_ST;
    end
    if (!nrst_in) begin
      run_next = RUN_ST;
    end
  end

  always_ff @(posedge core_clk_in) begin
    run_reg <= run_next;
  end

  // Group: timeout index and expiry option
  always_comb begin
    // Held through a stall, so resume reuses it
    index_next   = index_reg;
    exc_sel_next = exc_sel_reg;
    if (ctrl_wr) begin
      exc_sel_next = hwdata_in[CTRL_EXC_BIT];
      // An index above the top is dropped; the option bit still lands
      if (index_ok(wr_index)) begin
        index_next = wr_index;
      end
    end
    if (!nrst_in) begin
      index_next   = INDEX_RESET;
      exc_sel_next = 1'b0;
    end
  end

  always_ff @(posedge core_clk_in) begin
    index_reg   <= index_next;
    exc_sel_reg <= exc_sel_next;
  end

  // Group: step divider
  // Sleep, deep sleep and debug stall freeze the count; flash busy does not
  assign halted   = sys_sync.sleep || sys_sync.deep_sleep || sys_sync.debug_stall;
  assign running  = (run_reg == RUN_ST);
  assign counting = running && !halted;
  assign step     = counting && (div_reg >= 32'(STEP_CYC - 1));

  always_comb begin
    div_next = div_reg;
    // Divider keeps its count while halted, so a stall loses no time
    if (step) begin
      div_next = '0;
    end else if (counting) begin
      div_next = div_reg + 32'h0000_0001;
    end
    // Restart clears the part step too, so a full period follows
    if (cmd_kick) begin
      div_next = '0;
    end
    if (!nrst_in) begin
      div_next = '0;
    end
  end

  always_ff @(posedge core_clk_in) begin
    div_reg <= div_next;
  end

  // Group: progress counter; one step is 1/256 of the period
  assign mult     = period_mult(index_reg);
  assign sub_wrap = (sub_reg + 13'h0001) >= mult;
  assign prog_top = (prog_reg == PROG_MAX);
  assign expire   = step && sub_wrap && prog_top;
  // A restart in the same cycle cancels the expiry
  assign fire     = expire && !cmd_kick;

  always_comb begin
    sub_next  = sub_reg;
    prog_next = prog_reg;
    if (step) begin
      if (sub_wrap) begin
        sub_next  = '0;
        // Wraps to 0 after the top step, so counting goes on
        prog_next = prog_reg + 8'h01;
      end else begin
        sub_next = sub_reg + 13'h0001;
      end
    end
    if (cmd_kick) begin
      sub_next  = '0;
      prog_next = '0;
    end
    if (!nrst_in) begin
      sub_next  = '0;
      prog_next = '0;
    end
  end

  always_ff @(posedge core_clk_in) begin
    sub_reg  <= sub_next;
    prog_reg <= prog_next;
  end

  // Group: reset cause flag
  always_comb begin
    flag_next     = flag_reg;
    flag_cap_next = 1'b1;
    // Cause is taken from the reset logic once, just after release
    if (!flag_cap_reg) begin
      flag_next = wdt_reset_seen_in;
    end
    if (cmd_clrf) begin
      flag_next = 1'b0;
    end
    // Expiry set wins over a coinciding clear
    if (fire) begin
      flag_next = 1'b1;
    end
    if (!nrst_in) begin
      flag_next     = 1'b0;
      flag_cap_next = 1'b0;
    end
  end

  always_ff @(posedge core_clk_in) begin
    flag_reg     <= flag_next;
    flag_cap_reg <= flag_cap_next;
  end

  // Group: expiry pulses, one cycle each
  always_comb begin
    exp_next = '0;
    if (fire) begin
      exp_next.exception  = exc_sel_reg;
      exp_next.chip_reset = !exc_sel_reg;
      // Flash level lags the pin by the sync delay
      exp_next.prog_mode  = !exc_sel_reg && sys_sync.flash_busy;
    end
    if (!nrst_in) begin
      exp_next = '0;
    end
  end

  always_ff @(posedge core_clk_in) begin
    exp_reg <= exp_next;
  end

  assign chip_reset_out = exp_reg.chip_reset;
  assign exception_out  = exp_reg.exception;
  assign prog_mode_out  = exp_reg.prog_mode;

endmodule // watchdog_timeout_unit

// [hw/wdt_pkg.sv]
// Purpose: Constants and types for the watchdog timeout unit.
// Assumes: 200 MHz core clock, AHB-Lite register access.
// Notes:   Function
package wdt_pkg;

  localparam int          CLK_HZ         = 200_000_000;
  localparam int          TICK_US        = 31;
  // One progress step of index 0: 8 ms / 256 = 31.25 us, kept exact in ns
  localparam longint      STEP_NS        = 64'd31250;
  localparam longint      CLK_NS         = 64'd5;
  localparam int          STEP_CYCLES    = int'(STEP_NS / CLK_NS);
  localparam logic [3:0]  INDEX_MAX      = 4'hC;
  localparam logic [3:0]  INDEX_RESET    = 4'hC;
  localparam logic [7:0]  PROG_MAX       = 8'hFF;

  localparam logic [11:0] ADDR_CTRL      = 12'h000;
  localparam logic [11:0] ADDR_CMD       = 12'h004;
  localparam logic [11:0] ADDR_STATUS    = 12'h008;
  localparam logic [11:0] ADDR_PROGRESS  = 12'h00C;

  localparam int          CTRL_IDX_LSB   = 0;
  localparam int          CTRL_EXC_BIT   = 4;
  localparam int          CMD_START_BIT  = 0;
  localparam int          CMD_STOP_BIT   = 1;
  localparam int          CMD_KICK_BIT   = 2;
  localparam int          CMD_CLRF_BIT   = 3;
  localparam int          ST_RUN_BIT     = 0;
  localparam int          ST_FLAG_BIT    = 1;

  typedef enum logic [1:0] {
    RUN_ST  = 2'b00,
    STOP_ST = 2'b01
  } run_state_t;

  typedef struct packed {
    logic sleep;
    logic deep_sleep;
    logic debug_stall;
    logic flash_busy;
  } sys_state_t;

  typedef struct packed {
    logic chip_reset;
    logic exception;
    logic prog_mode;
  } expiry_t;

  // Steps of 1/256 period scale with the period multiplier
  function automatic logic [12:0] period_mult(input logic [3:0] idx);
    logic [12:0] m;
    m = 13'h0001;
    if (idx != 4'h0) begin
      m = 13'(13'h0001 << (idx - 4'h1)) + 13'h0001;
    end
    return m;
  endfunction

endpackage

// [hw/wdt_sync2.sv]
`timescale 1ns/1ps
// Purpose: Two-flop synchroniser for asynchronous level inputs.
// Assumes: Inputs are slow levels.
// Notes:   First stage feeds only the second.
module wdt_sync2 #(
  parameter int W = 4
) (
  input  wire logic         core_clk_in,
  input  wire logic         nrst_in,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] stage1_reg;
  logic [W-1:0] stage1_next;
  logic [W-1:0] stage2_next;

  always_comb begin
    stage1_next = nrst_in ? async_in : '0;
    stage2_next = nrst_in ? stage1_reg : '0;
  end

  always_ff @(posedge core_clk_in) begin
    stage1_reg <= stage1_next;
    sync_out   <= stage2_next;
  end
endmodule // wdt_sync2

// [verif/test_watchdog_timeout_unit.sv]
// Purpose: Bus-level tests of the watchdog timeout unit.
// Assumes: STEP_CYC of 2, so index 0 runs out 512 cycles after a kick.
// Notes:   Index 12 is far too long to run out here.
`timescale 1ns/1ps
`define CHK(g, x) begin checks_done++; if ((g) !== (x)) begin miscompares++; \
  $display("mismatch at %0t: got %0h want %0h", $time, g, x); end end
module test_watchdog_timeout_unit;
  import wdt_pkg::*;
  localparam int SC = 2;
  logic        core_clk_in, nrst_in, hsel_in, hwrite_in, seen;
  logic [11:0] haddr_in;
  logic [1:0]  htrans_in;
  logic [31:0] hwdata_in, hrdata_out, rd_q, a, b;
  wire logic   hready;
  sys_state_t  sys;
  wire expiry_t ex;
  expiry_t     e;
  int          miscompares = 0, checks_done = 0, cycles = 0, n, per;

  watchdog_timeout_unit #(.STEP_CYC(SC)) watchdog_timeout_unit_i (
    .core_clk_in(core_clk_in), .nrst_in(nrst_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
    .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(3'h2), .hwdata_in(hwdata_in),
    .hready_in(hready), .hrdata_out(hrdata_out), .hreadyout_out(hready), .hresp_out(),
    .sleep_in(sys.sleep), .deep_sleep_in(sys.deep_sleep), .debug_stall_in(sys.debug_stall),
    .flash_busy_in(sys.flash_busy), .wdt_reset_seen_in(seen),
    .chip_reset_out(ex.chip_reset), .exception_out(ex.exception), .prog_mode_out(ex.prog_mode));

  initial begin
    core_clk_in = 1'b0;
    forever #2.5 core_clk_in = ~core_clk_in;
  end

  // Read data captured at the edge that ends the data phase
  always @(posedge core_clk_in) begin
    rd_q <= hrdata_out;
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic bus(input logic w, input logic [11:0] ad, input logic [31:0] wd);
    @(posedge core_clk_in);
    hsel_in <= 1'b1;
    htrans_in <= 2'b10;
    hwrite_in <= w;
    haddr_in <= ad;
    do @(posedge core_clk_in); while (hready !== 1'b1);
    hsel_in <= 1'b0;
    htrans_in <= 2'b00;
    hwdata_in <= wd;
    do @(posedge core_clk_in); while (hready !== 1'b1);
    @(negedge core_clk_in);
    b = rd_q;
  endtask

  task automatic rdchk(input logic [11:0] ad, input logic [31:0] m, input logic [31:0] x);
    bus(1'b0, ad, 32'h0);
    `CHK(b & m, x)
  endtask

  task automatic cmd(input int bit_pos);
    bus(1'b1, ADDR_CMD, 32'(1 << bit_pos));
  endtask

  // Progress is trusted only once two reads in a row agree
  task automatic rdprog();
    logic [31:0] prev;
    prev = 32'hFFFF_FFFF;
    bus(1'b0, ADDR_PROGRESS, 32'h0);
    while (b !== prev) begin
      prev = b;
      bus(1'b0, ADDR_PROGRESS, 32'h0);
    end
    `CHK(b & 32'hFFFFFF00, 32'h0)
  endtask

  // Cycles from the end of the kick to the first expiry pulse
  task automatic expire();
    n = 0;
    e = '0;
    while (e == '0 && n < 5000) begin
      @(negedge core_clk_in);
      n++;
      e = ex;
    end
  endtask

  initial begin
    nrst_in = 1'b0;
    seen = 1'b0;
    sys = '0;
    hsel_in = 1'b0;
    hwrite_in = 1'b0;
    haddr_in = '0;
    htrans_in = '0;
    hwdata_in = '0;
    repeat (3) @(posedge core_clk_in);
    nrst_in <= 1'b1;
    rdchk(ADDR_STATUS, 32'h3, 32'h1);
    rdchk(ADDR_CTRL, 32'h1F, 32'h0C);
    bus(1'b1, ADDR_CTRL, 32'h0D);
    rdchk(ADDR_CTRL, 32'hF, 32'hC);
    for (int p = 0; p < 3; p++) begin
      per = (p == 0 ? 1 : (1 << (p - 1)) + 1) * 256 * SC;
      bus(1'b1, ADDR_CTRL, 32'(p));
      cmd(CMD_KICK_BIT);
      expire();
      `CHK(n > per - 5 && n < per + 5, 1'b1)
      `CHK(e, 3'b100)
      rdchk(ADDR_STATUS, 32'h2, 32'h2);
    end
    cmd(CMD_CLRF_BIT);
    rdchk(ADDR_STATUS, 32'h2, 32'h0);
    for (int k = 0; k < 2; k++) begin
      bus(1'b1, ADDR_CTRL, k ? 32'h0 : 32'h10);
      @(posedge core_clk_in);
      sys <= k ? 4'h1 : 4'h0;
      cmd(CMD_KICK_BIT);
      expire();
      `CHK(e, k ? 3'b101 : 3'b010)
    end
    $display("test expiry kinds done");
    @(posedge core_clk_in);
    sys <= '0;
    cmd(CMD_KICK_BIT);
    repeat (300) @(negedge core_clk_in);
    rdchk(ADDR_PROGRESS, 32'h0, 32'h0);
    `CHK(b > 140 && b < 160, 1'b1)
    cmd(CMD_KICK_BIT);
    rdchk(ADDR_PROGRESS, 32'hFFFFFFFC, 32'h0);
    repeat (100) @(negedge core_clk_in);
    rdchk(ADDR_PROGRESS, 32'h0, 32'h0);
    a = b;
    bus(1'b1, ADDR_CTRL, 32'h1);
    cmd(CMD_START_BIT);
    rdchk(ADDR_PROGRESS, 32'h0, 32'h0);
    `CHK(b >= a && b < a + 8, 1'b1)
    bus(1'b1, ADDR_CTRL, 32'h0);
    // Pass 0 stops by command, later passes stall by debug, deep sleep, sleep
    for (int i = 0; i < 4; i++) begin
      cmd(CMD_KICK_BIT);
      if (i == 0)
        cmd(CMD_STOP_BIT);
      @(posedge core_clk_in);
      sys <= 4'(1 << i) & 4'hE;
      repeat (10) @(negedge core_clk_in);
      rdprog();
      a = b;
      repeat (600) @(negedge core_clk_in);
      rdprog();
      `CHK(b & 32'hFF, a)
      if (i == 0)
        rdchk(ADDR_STATUS, 32'h1, 32'h0);
      @(posedge core_clk_in);
      sys <= '0;
      if (i == 0)
        cmd(CMD_START_BIT);
      repeat (40) @(negedge core_clk_in);
      rdchk(ADDR_PROGRESS, 32'h0, 32'h0);
      `CHK(b > a, 1'b1)
    end
    rdchk(ADDR_CTRL, 32'hF, 32'h0);
    $display("test stall and stop done");
    @(posedge core_clk_in);
    nrst_in <= 1'b0;
    seen <= 1'b1;
    repeat (3) @(posedge core_clk_in);
    nrst_in <= 1'b1;
    rdchk(ADDR_STATUS, 32'h3, 32'h3);
    $display("test reset cause done");
    end_sim();
  end
endmodule // test_watchdog_timeout_unit

// [verif/watchdog_timeout_unit_props.sv]
// Purpose: Port assertions for the watchdog timeout unit.
// Assumes: Stall and flash levels pass a two-flop synchroniser.
// Notes:   Six-cycle holds allow for that sync delay.
`timescale 1ns/1ps
module watchdog_timeout_unit_props (
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic hreadyout_out,
  input wire logic hresp_out,
  input wire logic sleep_in,
  input wire logic deep_sleep_in,
  input wire logic debug_stall_in,
  input wire logic flash_busy_in,
  input wire logic chip_reset_out,
  input wire logic exception_out,
  input wire logic prog_mode_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);
  wire logic pulse = chip_reset_out | exception_out;
  wire logic stall = sleep_in | deep_sleep_in | debug_stall_in;
  a_bus_ready_okay: assert property (hreadyout_out && !hresp_out)
    else $error("bus stalled or erred");
  a_expiry_one_kind: assert property (!(chip_reset_out && exception_out))
    else $error("reset and exception together");
  a_prog_needs_reset: assert property (prog_mode_out |-> chip_reset_out)
    else $error("prog mode without reset");
  a_reset_one_cycle: assert property (chip_reset_out |=> !chip_reset_out)
    else $error("long chip reset");
  a_exc_one_cycle: assert property ($rose(exception_out) |=> $fell(exception_out))
    else $error("long exception");
  a_quiet_after_reset: assert property ($rose(nrst_in) |-> !pulse && !prog_mode_out)
    else $error("output after reset");
  a_stall_no_expiry: assert property (stall [*6] |-> !pulse)
    else $error("expiry while stalled");
  a_flash_gives_prog: assert property (flash_busy_in [*6] ##0 chip_reset_out |-> prog_mode_out)
    else $error("no prog mode");
  a_idle_no_prog: assert property (!flash_busy_in [*6] ##0 chip_reset_out |-> !prog_mode_out)
    else $error("stray prog mode");
  c_chip_reset: cover property (chip_reset_out);
  c_exception: cover property (exception_out);
  c_prog_mode: cover property (prog_mode_out);
endmodule // watchdog_timeout_unit_props

bind watchdog_timeout_unit watchdog_timeout_unit_props watchdog_timeout_unit_props_i (.*);
